/* File: verilog/watchdog_timer_unit.sv */
// Watchdog timer unit with AHB-Lite register slave
//
// Decided for this implementation: the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none

// Overview of operation
// (R1) Counter runs freely; only reset and interrupt outputs have enables. Here the count holds in PH_EXPIRED after a time-out with reset enable.
// (R2) Counter advances on every crystal clock, not on machine cycles.
// (R3) Select codes 00..11 give 2^17, 2^20, 2^23, 2^26 clock warnings.
// (R4) Time-out select lives in bits 7 and 6 of clock speed register.
// (R5) Warning flag, control bit 3, sets at selected count regardless of enable.
// (R6) Timeout flag, control bit 2, sets exactly 512 clocks after warning.
// (R7) With reset enable, control bit 1, full time-out requests CPU reset.
// (R8) Writing one to restart, control bit 0, begins a fresh interval.
// (R9) Reset enable and restart writes only take effect while unlocked.
// (R10) Interrupt request gated by extended enable bit 4, apart from reset.
// (R11) Enabled watchdog interrupt also raises a wake request.
// (R12) Software should restart before changing the time-out select.
// (R13) Keys AA then 55 to C7 open a three-cycle single-write window.
// (R14) Warning flag and power-on flag are protected by the same unlock.
// (R15) Option input chooses power-up reset enable: one disables, zero enables.
// (R16) Restart zeroes counter and re-arms; flags stay until written zero.
// (R17) Any reset restarts the counter and returns select to code 00.
module watchdog_timer_unit #(
    parameter logic [26:0] SEL0_CLKS = 27'h0020000,
    parameter logic [26:0] SEL1_CLKS = 27'h0100000,
    parameter logic [26:0] SEL2_CLKS = 27'h0800000,
    parameter logic [26:0] SEL3_CLKS = 27'h4000000
) (
    input  wire logic        CLK,
    input  wire logic        RESET,
    input  wire logic        HSEL,
    input  wire logic [31:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output logic             HREADYOUT,
    output logic [31:0]      HRDATA,
    output logic             HRESP,
    input  wire logic        WDOG_RESET_POR_DISABLE,
    output logic             WDOG_TIMEOUT_IRQ,
    output logic             WAKE_REQ,
    output logic             IRQ,
    output logic             CPU_RESET_REQ
);
    import wdt_pkg::*;

    typedef struct packed {
        wdog_phase_t        phase;
        logic [COUNT_W-1:0] count;
        logic [7:0]         clock_speed;
        logic [7:0]         ext_irq_en;
        logic               warn_flag;
        logic               timeout_flag;
        logic               reset_enable;
        logic               por_flag;
        logic               strap_pending;
        logic               cpu_reset;
        logic [EVT_W-1:0]   irq_status;
        logic [EVT_W-1:0]   irq_mask;
        ahb_dphase_t        dphase;
        logic [7:0]         rdata;
        logic               hready;
        logic               hresp;
        logic               wdog_irq;
        logic               wake;
        logic               irq;
    } wdt_state_t;

    wdt_state_t         st;
    wdt_state_t         next_st;
    logic               accept;
    logic               wr_en;
    logic               wr_wdog;
    logic [7:0]         wdata;
    logic               ta_open;
    logic               restart_now;
    logic               warn_ev;
    logic               timeout_ev;
    logic [COUNT_W-1:0] limit_now;
    logic [IDX_W-1:0]   addr_idx;
    ta_write_t          ta_wr;

    function automatic logic [COUNT_W-1:0] wdog_limit(input logic [1:0] sel);
        logic [COUNT_W-1:0] lim;
        lim = SEL0_CLKS;
        unique case (sel)
            2'h0: lim = SEL0_CLKS;
            2'h1: lim = SEL1_CLKS;
            2'h2: lim = SEL2_CLKS;
            2'h3: lim = SEL3_CLKS;
        endcase
        return lim;
    endfunction

    function automatic logic [7:0] reg_value(input wdt_state_t s, input logic [IDX_W-1:0] idx);
        logic [7:0] v;
        v = 8'h00;
        case (idx)
            IDX_CLOCK_SPEED: begin
                v = s.clock_speed;
            end
            IDX_WDOG_CTRL: begin
                v[POR_BIT] = s.por_flag;
                v[WARN_BIT] = s.warn_flag;
                v[TIMEOUT_BIT] = s.timeout_flag;
                v[RESET_EN_BIT] = s.reset_enable;
            end
            IDX_EXT_IRQ_EN: begin
                v = s.ext_irq_en;
            end
            IDX_IRQ_STATUS: begin
                v[EVT_W-1:0] = s.irq_status;
            end
            IDX_IRQ_MASK: begin
                v[EVT_W-1:0] = s.irq_mask;
            end
            default: begin
                v = 8'h00;
            end
        endcase
        return v;
    endfunction

    // Zero-wait slave: a write lands at the end of its data phase
    assign accept = HSEL && HREADY && HTRANS[HTRANS_ACTIVE_BIT];
    assign addr_idx = (HADDR[31:ADDR_IDX_MSB+1] == '0) ? HADDR[ADDR_IDX_MSB:ADDR_IDX_LSB] : IDX_NONE;
    assign wr_en = st.dphase.valid && st.dphase.write;
    assign wr_wdog = wr_en && (st.dphase.idx == IDX_WDOG_CTRL);
    assign wdata = HWDATA[7:0];
    assign ta_wr = {wr_en, st.dphase.idx == IDX_TIMED_ACCESS, wdata};
    assign restart_now = wr_wdog && ta_open && wdata[RESTART_BIT] && !RESET; // see (R8) (R9)
    assign limit_now = wdog_limit(st.clock_speed[SEL_HI_BIT:SEL_LO_BIT]); // see (R3) (R4)

    timed_access_unlock unlock (
        .CLK   (CLK),
        .RESET (RESET),
        .wr    (ta_wr),
        .open  (ta_open)
    );

    // Counter sequencing; only a time-out with reset enable stops it, in PH_EXPIRED
    always_comb begin
        warn_ev = 1'b0;
        timeout_ev = 1'b0;
        unique case (st.phase)
            PH_COUNT: begin
                // Compare with >= so a shorter select never misses its end
                if (st.count >= limit_now - 27'h0000001) begin
                    warn_ev = !restart_now; // see (R5)
                end
            end
            PH_WARN: begin
                if (st.count == TIMEOUT_GAP_CLKS - 27'h0000001) begin
                    timeout_ev = !restart_now; // see (R6)
                end
            end
            PH_EXPIRED: begin
                warn_ev = 1'b0;
            end
            default: begin
                warn_ev = 1'b0;
            end
        endcase
    end

    always_comb begin
        next_st = st;
        next_st.hready = 1'b1;
        next_st.hresp = HRESP_OKAY;

        // Register writes
        if (wr_en && st.dphase.idx == IDX_CLOCK_SPEED) begin
            next_st.clock_speed = wdata; // see (R4)
        end
        if (wr_en && st.dphase.idx == IDX_EXT_IRQ_EN) begin
            next_st.ext_irq_en = wdata;
        end
        if (wr_en && st.dphase.idx == IDX_IRQ_MASK) begin
            next_st.irq_mask = wdata[EVT_W-1:0];
        end
        if (wr_wdog) begin
            if (!wdata[TIMEOUT_BIT]) begin
                next_st.timeout_flag = 1'b0; // see (R16)
            end
            if (ta_open) begin
                next_st.reset_enable = wdata[RESET_EN_BIT]; // see (R9)
                if (!wdata[WARN_BIT]) begin
                    next_st.warn_flag = 1'b0; // see (R14) (R16)
                end
                if (!wdata[POR_BIT]) begin
                    next_st.por_flag = 1'b0; // see (R14)
                end
            end
        end

        // Crystal clock is the time base: one step per CLK edge
        unique case (st.phase)
            PH_COUNT: begin
                if (warn_ev) begin
                    next_st.phase = PH_WARN;
                    next_st.count = '0;
                end else begin
                    next_st.count = st.count + 27'h0000001; // see (R1) (R2)
                end
            end
            PH_WARN: begin
                if (timeout_ev) begin
                    next_st.count = '0;
                    // Without reset enable the chain just wraps as a time base
                    next_st.phase = st.reset_enable ? PH_EXPIRED : PH_COUNT; // see (R7)
                end else begin
                    next_st.count = st.count + 27'h0000001; // see (R6)
                end
            end
            PH_EXPIRED: begin
                next_st.count = st.count;
            end
            default: begin
                next_st.phase = PH_COUNT;
                next_st.count = '0;
            end
        endcase
        if (restart_now) begin
            next_st.phase = PH_COUNT; // see (R8) (R16)
            next_st.count = '0;
        end

        // Hardware set wins over a same-cycle software clear
        if (warn_ev) begin
            next_st.warn_flag = 1'b1; // see (R5)
        end
        if (timeout_ev) begin
            next_st.timeout_flag = 1'b1; // see (R6)
        end
        if (timeout_ev && st.reset_enable) begin
            next_st.cpu_reset = 1'b1; // see (R7)
        end

        // Power-up reset enable taken from the option input after release
        if (st.strap_pending) begin
            next_st.reset_enable = !WDOG_RESET_POR_DISABLE; // see (R15)
            next_st.strap_pending = 1'b0;
        end

        // Address phase; status is cleared by its own read
        next_st.dphase.valid = accept;
        next_st.dphase.write = HWRITE;
        next_st.dphase.idx = addr_idx;
        if (accept && !HWRITE) begin
            next_st.rdata = reg_value(st, addr_idx);
            if (addr_idx == IDX_IRQ_STATUS) begin
                next_st.irq_status = '0;
            end
        end
        if (warn_ev) begin
            next_st.irq_status[EVT_WARN_BIT] = 1'b1;
        end
        if (timeout_ev) begin
            next_st.irq_status[EVT_TIMEOUT_BIT] = 1'b1;
        end

        // Outputs registered from the next state so they track flags exactly
        next_st.wdog_irq = next_st.warn_flag && next_st.ext_irq_en[IRQ_EN_BIT]; // see (R10)
        next_st.wake = next_st.wdog_irq; // see (R11)
        next_st.irq = |(next_st.irq_status & next_st.irq_mask);

        if (RESET) begin
            next_st = '0; // see (R17)
            next_st.phase = PH_COUNT;
            next_st.clock_speed = CLOCK_SPEED_RESET;
            next_st.ext_irq_en = EXT_IRQ_EN_RESET;
            next_st.irq_mask = IRQ_MASK_RESET;
            next_st.por_flag = 1'b1;
            next_st.strap_pending = 1'b1;
            next_st.hready = 1'b1;
            next_st.hresp = HRESP_OKAY;
        end
    end

    always_ff @(posedge CLK) begin
        st <= next_st;
    end

    assign HREADYOUT = st.hready;
    assign HRDATA = {24'h000000, st.rdata};
    assign HRESP = st.hresp;
    assign WDOG_TIMEOUT_IRQ = st.wdog_irq;
    assign WAKE_REQ = st.wake;
    assign IRQ = st.irq;
    assign CPU_RESET_REQ = st.cpu_reset;

    free_run_a: assert property (@(posedge CLK) disable iff (RESET) // see (R1)
        st.phase == PH_COUNT && !restart_now && !warn_ev |=> st.count == $past(st.count) + 27'h0000001)
        else $error("counter failed to advance");

    warn_at_limit_a: assert property (@(posedge CLK) disable iff (RESET) // see (R3)
        st.phase == PH_COUNT && !restart_now && st.count == limit_now - 27'h0000001
        |=> st.phase == PH_WARN && st.warn_flag && st.count == '0)
        else $error("warning not raised at selected count");

    warn_cause_a: assert property (@(posedge CLK) disable iff (RESET) // see (R5)
        $rose(st.warn_flag) |-> $past(st.phase) == PH_COUNT && $past(st.count) >= $past(limit_now) - 27'h0000001)
        else $error("warning flag set without a completed count");

    gap_512_a: assert property (@(posedge CLK) disable iff (RESET) // see (R6)
        st.phase == PH_WARN && st.count == TIMEOUT_GAP_CLKS - 27'h0000001 && !restart_now
        |=> st.timeout_flag && st.irq_status[EVT_TIMEOUT_BIT])
        else $error("timeout flag missing 512 clocks after warning");

    timeout_cause_a: assert property (@(posedge CLK) disable iff (RESET) // see (R6)
        $rose(st.timeout_flag) |-> $past(st.phase == PH_WARN && st.count == TIMEOUT_GAP_CLKS - 27'h0000001))
        else $error("timeout flag set at the wrong moment");

    cpu_reset_a: assert property (@(posedge CLK) disable iff (RESET) // see (R7)
        $rose(CPU_RESET_REQ) |-> $past(st.reset_enable) && $past(timeout_ev) ##1 CPU_RESET_REQ [*3])
        else $error("cpu reset request wrong or not held");

    restart_a: assert property (@(posedge CLK) disable iff (RESET) // see (R8)
        restart_now |=> st.count == '0 && st.phase == PH_COUNT ##1 st.count == 27'h0000001)
        else $error("restart did not begin a new interval");

    locked_write_a: assert property (@(posedge CLK) disable iff (RESET) // see (R9)
        wr_wdog && !ta_open && !st.strap_pending
        |=> $stable(st.reset_enable) && !$fell(st.warn_flag) && !$fell(st.por_flag))
        else $error("protected bit changed without unlock");

    irq_gate_a: assert property (@(posedge CLK) disable iff (RESET) // see (R10)
        WDOG_TIMEOUT_IRQ == (st.warn_flag && st.ext_irq_en[IRQ_EN_BIT]))
        else $error("watchdog interrupt not gated by its enable");

    wake_a: assert property (@(posedge CLK) disable iff (RESET) // see (R11)
        $rose(WDOG_TIMEOUT_IRQ) |-> WAKE_REQ)
        else $error("wake request missing for watchdog interrupt");

    flag_sticky_a: assert property (@(posedge CLK) disable iff (RESET) // see (R16)
        st.timeout_flag && !(wr_wdog && !wdata[TIMEOUT_BIT]) |=> st.timeout_flag)
        else $error("timeout flag cleared without a write");

    strap_a: assert property (@(posedge CLK) disable iff (RESET) // see (R15)
        st.strap_pending |=> st.reset_enable == !$past(WDOG_RESET_POR_DISABLE))
        else $error("power-up reset enable not taken from option");

    reset_state_a: assert property (@(posedge CLK) disable iff (RESET) // see (R17)
        $past(RESET) |-> st.count == '0 && st.clock_speed[SEL_HI_BIT:SEL_LO_BIT] == 2'h0 && !CPU_RESET_REQ)
        else $error("reset did not restart the watchdog");
endmodule // watchdog_timer_unit
`default_nettype wire

/* File: verilog/wdt_pkg.sv */
// Shared constants and types of the watchdog timer unit
package wdt_pkg;
    localparam int COUNT_W = 27;
    localparam int IDX_W = 8;
    localparam int EVT_W = 2;
    // Register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_CLOCK_SPEED = 8'h8E;
    localparam logic [IDX_W-1:0] IDX_WDOG_CTRL = 8'hD8;
    localparam logic [IDX_W-1:0] IDX_EXT_IRQ_EN = 8'hE8;
    localparam logic [IDX_W-1:0] IDX_TIMED_ACCESS = 8'hC7;
    localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 8'hF0;
    localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 8'hF1;
    localparam logic [IDX_W-1:0] IDX_NONE = 8'h00;
    localparam int ADDR_IDX_LSB = 2;
    localparam int ADDR_IDX_MSB = 9;
    localparam int HTRANS_ACTIVE_BIT = 1;
    localparam logic HRESP_OKAY = 1'b0;
    // Field positions
    localparam int SEL_HI_BIT = 7;
    localparam int SEL_LO_BIT = 6;
    localparam int POR_BIT = 6;
    localparam int WARN_BIT = 3;
    localparam int TIMEOUT_BIT = 2;
    localparam int RESET_EN_BIT = 1;
    localparam int RESTART_BIT = 0;
    localparam int IRQ_EN_BIT = 4;
    localparam int EVT_WARN_BIT = 0;
    localparam int EVT_TIMEOUT_BIT = 1;
    // Timed access
    localparam logic [7:0] TA_KEY_FIRST = 8'hAA;
    localparam logic [7:0] TA_KEY_SECOND = 8'h55;
    localparam logic [1:0] TA_WINDOW_CYCLES = 2'h3;
    // Timing and reset values
    localparam logic [COUNT_W-1:0] TIMEOUT_GAP_CLKS = 27'h0000200;
    localparam logic [7:0] CLOCK_SPEED_RESET = 8'h00;
    localparam logic [7:0] EXT_IRQ_EN_RESET = 8'h00;
    localparam logic [EVT_W-1:0] IRQ_MASK_RESET = 2'h0;

    typedef enum logic [1:0] {
        PH_COUNT   = 2'h0,
        PH_WARN    = 2'h1,
        PH_EXPIRED = 2'h3
    } wdog_phase_t;

    typedef struct packed {
        logic             valid;
        logic             write;
        logic [IDX_W-1:0] idx;
    } ahb_dphase_t;

    typedef struct packed {
        logic       commit;
        logic       is_ta;
        logic [7:0] data;
    } ta_write_t;
endpackage

/* File: verilog/timed_access_unlock.sv */
// Timed-access unlock sequencer for the protected watchdog bits
`timescale 1ns/10ps
`default_nettype none
module timed_access_unlock (
    input  wire logic               CLK,
    input  wire logic               RESET,
    input  wire wdt_pkg::ta_write_t wr,
    output logic                    open
);
    import wdt_pkg::*;

    typedef struct packed {
        logic [1:0] arm;
        logic [1:0] window;
    } ta_state_t;

    ta_state_t st;
    ta_state_t next_st;

    always_comb begin
        next_st = st;
        if (st.arm != 2'h0) begin
            next_st.arm = st.arm - 2'h1;
        end
        if (st.window != 2'h0) begin
            next_st.window = st.window - 2'h1;
        end
        // Any other write breaks the sequence or uses up the window
        if (wr.commit) begin
            next_st.arm = 2'h0;
            next_st.window = 2'h0;
            if (wr.is_ta && wr.data == TA_KEY_FIRST) begin
                next_st.arm = TA_WINDOW_CYCLES; // see (R13)
            end else if (wr.is_ta && wr.data == TA_KEY_SECOND && st.arm != 2'h0) begin
                next_st.window = TA_WINDOW_CYCLES; // see (R13)
            end
        end
        if (RESET) begin
            next_st = '0;
        end
    end

    always_ff @(posedge CLK) begin
        st <= next_st;
    end

    assign open = (st.window != 2'h0);

    window_len_a: assert property (@(posedge CLK) disable iff (RESET) // see (R13)
        open [*3] |=> !open)
        else $error("unlock window longer than three cycles");

    key_order_a: assert property (@(posedge CLK) disable iff (RESET) // see (R13)
        $rose(open) |-> $past(wr.commit && wr.is_ta && wr.data == TA_KEY_SECOND && st.arm != 2'h0))
        else $error("unlock window opened without the key sequence");

    one_write_a: assert property (@(posedge CLK) disable iff (RESET) // see (R13)
        open && wr.commit && !wr.is_ta |=> !open)
        else $error("unlock window survived a write");
endmodule // timed_access_unlock
`default_nettype wire

/* File: testbench/cpu_core_model.sv */
// Behavioural CPU core reset and interrupt logic facing the watchdog
`timescale 1ns/10ps
`default_nettype none
module cpu_core_model (
    input  wire logic   clk,
    input  wire logic   irq_line,
    input  wire logic   wdog_irq,
    input  wire logic   reset_req,
    output logic [31:0] cyc,
    output logic [31:0] irq_cyc,
    output logic [31:0] wdi_cyc,
    output logic [31:0] rst_cyc,
    output logic        core_held
);
    logic irq_q;
    logic wdi_q;
    logic rst_q;

    initial begin
        cyc = 32'h0;
        irq_cyc = 32'h0;
        wdi_cyc = 32'h0;
        rst_cyc = 32'h0;
        core_held = 1'b0;
        irq_q = 1'b0;
        wdi_q = 1'b0;
        rst_q = 1'b0;
    end

    // Records the edge index at which each request most recently went high
    always @(posedge clk) begin
        cyc <= cyc + 32'h1;
        irq_q <= irq_line;
        wdi_q <= wdog_irq;
        rst_q <= reset_req;
        if (irq_line === 1'b1 && irq_q === 1'b0) irq_cyc <= cyc;
        if (wdog_irq === 1'b1 && wdi_q === 1'b0) wdi_cyc <= cyc;
        if (reset_req === 1'b1 && rst_q === 1'b0) rst_cyc <= cyc;
        // Core halts for as long as the reset request stands
        core_held <= reset_req;
    end
endmodule // cpu_core_model
`default_nettype wire

/* File: testbench/watchdog_timer_unit_tb.sv */
// Self-checking bench of the watchdog timer unit
`timescale 1ns/10ps
`default_nettype none
`define CHECK(got, ex) begin num_checks++; if ((got) !== (ex)) begin n_mismatch++; \
    $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, ex); end end
module watchdog_timer_unit_tb;
    import wdt_pkg::*;
    // Shortened counts keep the run short; the 512 gap stays fixed
    localparam int SEL_CLKS [4] = '{32'h1000, 32'h80, 32'h100, 32'h200};
    localparam int GAP = 32'h200;
    typedef struct packed {
        logic       wr;
        logic [7:0] idx;
        logic [7:0] wd;
        logic [7:0] ex;
    } row_t;
    localparam row_t ROWS [12] = '{
        '{1'b0, IDX_CLOCK_SPEED, 8'h00, 8'h00}, '{1'b0, IDX_WDOG_CTRL, 8'h00, 8'h40},
        '{1'b0, IDX_EXT_IRQ_EN, 8'h00, 8'h00}, '{1'b0, IDX_IRQ_MASK, 8'h00, 8'h00},
        '{1'b0, IDX_IRQ_STATUS, 8'h00, 8'h00}, '{1'b1, IDX_EXT_IRQ_EN, 8'h5A, 8'h5A},
        '{1'b1, IDX_EXT_IRQ_EN, 8'h00, 8'h00}, '{1'b1, IDX_IRQ_MASK, 8'h03, 8'h03},
        '{1'b1, IDX_TIMED_ACCESS, 8'h12, 8'h00}, '{1'b1, IDX_NONE, 8'hFF, 8'h00},
        '{1'b1, IDX_WDOG_CTRL, 8'h03, 8'h40}, '{1'b1, IDX_CLOCK_SPEED, 8'h3F, 8'h3F}};

    logic        clk, reset, hsel, hwrite, strap, hreadyout, hresp;
    logic        wdog_irq, wake, irq, cpu_rst, core_held;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] haddr, hwdata, hrdata, cyc, irq_cyc, wdi_cyc, rst_cyc, e, saved;
    int          n_mismatch, num_checks;

    watchdog_timer_unit #(
        .SEL0_CLKS(27'(SEL_CLKS[0])), .SEL1_CLKS(27'(SEL_CLKS[1])),
        .SEL2_CLKS(27'(SEL_CLKS[2])), .SEL3_CLKS(27'(SEL_CLKS[3]))
    ) u_watchdog_timer_unit (
        .CLK(clk), .RESET(reset), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
        .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout), .HREADYOUT(hreadyout), .HRDATA(hrdata),
        .HRESP(hresp), .WDOG_RESET_POR_DISABLE(strap), .WDOG_TIMEOUT_IRQ(wdog_irq), .WAKE_REQ(wake),
        .IRQ(irq), .CPU_RESET_REQ(cpu_rst));

    cpu_core_model u_cpu_core_model (
        .clk(clk), .irq_line(irq), .wdog_irq(wdog_irq), .reset_req(cpu_rst), .cyc(cyc),
        .irq_cyc(irq_cyc), .wdi_cyc(wdi_cyc), .rst_cyc(rst_cyc), .core_held(core_held));

    // Every task is entered and left in the time step of a rising edge
    task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] wd, output logic [31:0] v);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {22'h0, idx, 2'h0};
        hsize <= 3'h2;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        htrans <= 2'h0;
        hwdata <= {24'h0, wd};
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        v = hrdata;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
        logic [31:0] v;
        xfer(1'b1, idx, wd, v);
    endtask

    task automatic rchk(input logic [7:0] idx, input logic [7:0] ex);
        logic [31:0] v;
        xfer(1'b0, idx, 8'h00, v);
        `CHECK(v, {24'h0, ex})
        `CHECK(hresp, HRESP_OKAY)
    endtask

    task automatic unlock_ctrl(input logic [7:0] wd);
        wr(IDX_TIMED_ACCESS, TA_KEY_FIRST);
        wr(IDX_TIMED_ACCESS, TA_KEY_SECOND);
        wr(IDX_WDOG_CTRL, wd);
    endtask

    // Reads before the commit edge lands, hence the plus one
    task automatic restart_wdog(output logic [31:0] at);
        unlock_ctrl(8'h01);
        at = cyc + 32'h1;
    endtask

    // Returns at edge c; outputs read are those left by edge c-1
    task automatic wait_until(input logic [31:0] c);
        while (cyc < c) @(posedge clk);
    endtask

    task automatic end_sim;
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    initial begin
        repeat (40000) @(posedge clk);
        n_mismatch++;
        end_sim();
    end

    initial begin
        reset = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        strap = 1'b1;
        n_mismatch = 0;
        num_checks = 0;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        for (int i = 0; i < 12; i++) begin
            if (ROWS[i].wr) wr(ROWS[i].idx, ROWS[i].wd);
            rchk(ROWS[i].idx, ROWS[i].ex);
        end
        restart_wdog(e);
        wait_until(e + SEL_CLKS[0] + 32'h2);
        `CHECK(irq_cyc, e + SEL_CLKS[0])
        `CHECK(wdog_irq, 1'b0)
        rchk(IDX_WDOG_CTRL, 8'h08);
        rchk(IDX_IRQ_STATUS, 8'h01);
        wait_until(e + SEL_CLKS[0] + GAP + 32'h2);
        `CHECK(irq_cyc, e + SEL_CLKS[0] + GAP)
        `CHECK(cpu_rst, 1'b0)
        rchk(IDX_WDOG_CTRL, 8'h0C);
        rchk(IDX_IRQ_STATUS, 8'h02);
        for (int k = 1; k < 4; k++) begin
            restart_wdog(e);
            wr(IDX_CLOCK_SPEED, 8'(k << 6));
            restart_wdog(e);
            wait_until(e + SEL_CLKS[k] + 32'h2);
            `CHECK(irq_cyc, e + SEL_CLKS[k])
            rchk(IDX_IRQ_STATUS, 8'h01);
        end
        restart_wdog(e);
        wr(IDX_EXT_IRQ_EN, 8'h10);
        wait_until(e + SEL_CLKS[3] - 32'h14);
        saved = irq_cyc;
        restart_wdog(e);
        wait_until(e + 32'h28);
        `CHECK(irq_cyc, saved)
        rchk(IDX_WDOG_CTRL, 8'h00);
        wait_until(e + SEL_CLKS[3] + 32'h2);
        `CHECK(irq_cyc, e + SEL_CLKS[3])
        `CHECK(wdi_cyc, e + SEL_CLKS[3])
        `CHECK(wake, 1'b1)
        wr(IDX_WDOG_CTRL, 8'h00);
        @(posedge clk);
        `CHECK(wdog_irq, 1'b1)
        // A foreign write between the keys must spoil the unlock
        wr(IDX_TIMED_ACCESS, TA_KEY_FIRST);
        wr(IDX_EXT_IRQ_EN, 8'h10);
        wr(IDX_TIMED_ACCESS, TA_KEY_SECOND);
        wr(IDX_WDOG_CTRL, 8'h00);
        @(posedge clk);
        `CHECK(wdog_irq, 1'b1)
        // Window lapses after two idle cycles; the late write must be lost
        wr(IDX_TIMED_ACCESS, TA_KEY_FIRST);
        wr(IDX_TIMED_ACCESS, TA_KEY_SECOND);
        repeat (2) @(posedge clk);
        wr(IDX_WDOG_CTRL, 8'h00);
        @(posedge clk);
        `CHECK(wdog_irq, 1'b1)
        unlock_ctrl(8'h02);
        @(posedge clk);
        `CHECK(wdog_irq, 1'b0)
        wait_until(e + SEL_CLKS[3] + GAP + 32'h2);
        `CHECK(rst_cyc, e + SEL_CLKS[3] + GAP)
        `CHECK(core_held, 1'b1)
        wr(IDX_IRQ_MASK, 8'h00);
        @(posedge clk);
        `CHECK(irq, 1'b0)
        wr(IDX_IRQ_MASK, 8'h03);
        @(posedge clk);
        `CHECK(irq, 1'b1)
        rchk(IDX_IRQ_STATUS, 8'h03);
        @(posedge clk);
        `CHECK(irq, 1'b0)
        strap <= 1'b0;
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        rchk(IDX_WDOG_CTRL, 8'h42);
        rchk(IDX_CLOCK_SPEED, 8'h00);
        `CHECK(cpu_rst, 1'b0)
        // Count restarted five edges before this point
        e = cyc;
        wait_until(e + SEL_CLKS[0] + GAP - 32'h10);
        `CHECK(cpu_rst, 1'b0)
        wait_until(e + SEL_CLKS[0] + GAP);
        `CHECK(cpu_rst, 1'b1)
        end_sim();
    end
endmodule // watchdog_timer_unit_tb
`default_nettype wire
